//--- design/evm_pkg.sv
/*
  Shared constants for the event and power monitor control block:
  register offsets, field positions, timing figures and the output FSM states.
  Assumes a 100 MHz system clock.
*/
package evm_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;

  function automatic int unsigned evm_cyc_of_ns(input longint unsigned ns);
    longint unsigned c;
    c = ns / CLK_PERIOD_NS;
    if (c == 0) c = 1;
    return int'(c);
  endfunction : evm_cyc_of_ns

  // ---------------------------------------------------------------
  // Timing figures
  // ---------------------------------------------------------------
  localparam longint unsigned HYS_SHORT_NS = 64'd3_900_000;    // 3.9 ms
  localparam longint unsigned HYS_MID_NS   = 64'd16_625_000;   // 16.625 ms
  localparam longint unsigned HYS_LONG_NS  = 64'd31_250_000;   // 31.25 ms
  localparam longint unsigned SMP_2HZ_MS   = 64'd500;
  localparam longint unsigned SMP_1HZ_MS   = 64'd1000;
  localparam longint unsigned SMP_4S_MS    = 64'd4000;
  localparam longint unsigned MS_NS        = 64'd1_000_000;
  localparam longint unsigned PULSE_MS     = 64'd250;          // Inside 200..300 ms

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_COUNT  = 8'h0B;
  localparam logic [7:0] ADDR_EVENT_CTRL   = 8'h0E;
  localparam logic [7:0] ADDR_EVENT_INDEX  = 8'h0F;
  localparam logic [7:0] ADDR_CHARGE_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_SUPPLY_CTRL  = 8'h11;
  localparam logic [7:0] ADDR_BATWARN_CTRL = 8'h12;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int EVC_BAT_DIS   = 6;
  localparam int EVC_PULSE     = 5;
  localparam int EVC_ENABLE    = 4;
  localparam int EVC_HYS_LSB   = 2;
  localparam int EVC_SMP_LSB   = 0;
  localparam int CHG_ENABLE    = 2;
  localparam int CHG_RES_LSB   = 0;
  localparam int SUP_CLR_TS    = 7;
  localparam int SUP_BUS_BAT   = 5;
  localparam int SUP_TRIP_LSB  = 0;
  localparam int BW_HYS        = 6;
  localparam int BW_WARN1_LSB  = 3;
  localparam int BW_WARN2_LSB  = 0;

  localparam logic [7:0] MASK_EVENT_CTRL   = 8'h7F;
  localparam logic [7:0] MASK_EVENT_INDEX  = 8'h03;
  localparam logic [7:0] MASK_CHARGE_CTRL  = 8'h07;
  localparam logic [7:0] MASK_SUPPLY_CTRL  = 8'h27;  // Clear bit is self-clearing
  localparam logic [7:0] MASK_BATWARN_CTRL = 8'h7F;

  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [1:0] SEL_OFF       = 2'b00;
  localparam logic [1:0] SEL_1         = 2'b01;
  localparam logic [1:0] SEL_2         = 2'b10;
  localparam logic [1:0] IDX_LATEST    = 2'b11;

  // ---------------------------------------------------------------
  // Event output states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EVO_IDLE  = 3'b001,
    EVO_LATCH = 3'b010,
    EVO_PULSE = 3'b100
  } evm_out_state_t;

endpackage : evm_pkg

//--- design/evm_cond_if.sv
/*
  Carrier between the control top and the event input conditioner.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface evm_cond_if;
  logic       enable;
  logic [1:0] hys_sel;
  logic [1:0] smp_sel;
  logic       event_det;

  modport ctrl (output enable, output hys_sel, output smp_sel, input event_det);
  modport cond (input enable, input hys_sel, input smp_sel, output event_det);
endinterface : evm_cond_if

//--- design/evm_event_filter.sv
/*
  Event input conditioner: time-based deglitch then rate-limited sampling.
  Assumes the event input is synchronous to the clock; an event is a
  sampled fall of the input from high to low.
*/
`timescale 1ns/100ps
module evm_event_filter #(
  parameter int unsigned HYS1_CYC = 390_000,
  parameter int unsigned HYS2_CYC = 1_662_500,
  parameter int unsigned HYS3_CYC = 3_125_000,
  parameter int unsigned SMP1_CYC = 50_000_000,
  parameter int unsigned SMP2_CYC = 100_000_000,
  parameter int unsigned SMP3_CYC = 400_000_000
) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_srst,
  input  wire logic  i_event_input_pin,
  evm_cond_if.cond   cond
);
  import evm_pkg::*;

  logic        stable_q;
  logic [31:0] hys_cnt_q;
  logic [31:0] smp_cnt_q;
  logic        sampled_q;
  logic        det_q;
  logic [31:0] hys_lim;
  logic [31:0] smp_lim;
  logic        smp_tick;

  assign cond.event_det = det_q;

  // -----------------------------------------------------------------
  // Deglitch
  // -----------------------------------------------------------------
  always_comb begin
    case (cond.hys_sel)
      SEL_1:   hys_lim = HYS1_CYC;
      SEL_2:   hys_lim = HYS2_CYC;
      default: hys_lim = HYS3_CYC;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !cond.enable) begin
      stable_q  <= 1'b1;
      hys_cnt_q <= '0;
    end else if (i_event_input_pin == stable_q) begin
      hys_cnt_q <= '0;
    end else if (cond.hys_sel == SEL_OFF) begin
      stable_q  <= i_event_input_pin;
    end else if (hys_cnt_q + 32'd1 >= hys_lim) begin
      stable_q  <= i_event_input_pin;
      hys_cnt_q <= '0;
    end else begin
      hys_cnt_q <= hys_cnt_q + 32'd1;
    end
  end

  // -----------------------------------------------------------------
  // Sampling, independent of the deglitch setting
  // -----------------------------------------------------------------
  always_comb begin
    case (cond.smp_sel)
      SEL_1:   smp_lim = SMP1_CYC;
      SEL_2:   smp_lim = SMP2_CYC;
      default: smp_lim = SMP3_CYC;
    endcase
  end

  assign smp_tick = (cond.smp_sel == SEL_OFF) || (smp_cnt_q + 32'd1 >= smp_lim);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !cond.enable || smp_tick) begin
      smp_cnt_q <= '0;
    end else begin
      smp_cnt_q <= smp_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !cond.enable) begin
      sampled_q <= 1'b1;
      det_q     <= 1'b0;
    end else begin
      det_q <= 1'b0;
      if (smp_tick) begin
        sampled_q <= stable_q;
        det_q     <= sampled_q && !stable_q;
      end
    end
  end

endmodule : evm_event_filter

//--- design/evm_monitor_ctrl.sv
/*
  Event and power monitor control: register bank for event detect, event
  index, charge, supply trip and battery warning controls, plus the event
  counter and the active-low event detect output.
  Assumes the serial bus front end presents decoded one-cycle register
  write and read strobes with a byte address, and a one-cycle stop pulse
  after each successful write. Analog switches and comparators sit outside.
*/
// Notes on behaviour
// - On backup power the event output is forced idle when its battery disable bit is set.
// - Normal mode drives the event output low on an event until cleared.
// - Pulse mode gives one low pulse of 200 to 300 ms per event.
// - Event detection runs only while the detect enable bit is one.
// - Two-bit deglitch select: off, 3.9, 16.625 or 31.25 ms.
// - Deglitch and sampling settings act independently of each other.
// - Two-bit sample rate select: continuous, 2 Hz, 1 Hz or 1/4 Hz.
// - Four event stamp slots are kept while the counter counts to 255.
// - Index 0 is the first event; 1 to 3 the most recent, 3 latest.
// - Stamp reads use the slot chosen by the event index register.
// - Charge enable one closes the charge path; zero isolates the battery.
// - Two-bit charge resistor select drives the switch network.
// - Writing clear-stamps as one clears both switchover stamps after the write.
// - On backup power the bus answers only when bus-in-battery is one.
// - Three-bit supply trip select; low supply flag set below the trip.
// - Switchover hysteresis bit passes to the switchover comparator.
// - Three-bit first battery warning trip select.
// - Three-bit second battery warning trip select.
// - Event counter counts each event and holds at 255 until written zero.
`timescale 1ns/100ps
module evm_monitor_ctrl
  import evm_pkg::*;
#(
  parameter int unsigned HYS1_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::HYS_SHORT_NS),
  parameter int unsigned HYS2_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::HYS_MID_NS),
  parameter int unsigned HYS3_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::HYS_LONG_NS),
  parameter int unsigned SMP1_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::SMP_2HZ_MS * evm_pkg::MS_NS),
  parameter int unsigned SMP2_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::SMP_1HZ_MS * evm_pkg::MS_NS),
  parameter int unsigned SMP3_CYC  = evm_pkg::evm_cyc_of_ns(evm_pkg::SMP_4S_MS * evm_pkg::MS_NS),
  parameter int unsigned PULSE_CYC = evm_pkg::evm_cyc_of_ns(evm_pkg::PULSE_MS * evm_pkg::MS_NS)
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_wr_stop,
  input  wire logic       i_on_battery,
  input  wire logic       i_supply_below_trip,
  input  wire logic       i_event_input_pin,
  output logic      [7:0] o_reg_rdata,
  output logic            o_bus_enable,
  output logic            o_event_detect_output_n,
  output logic            o_ts_capture,
  output logic      [1:0] o_ts_capture_slot,
  output logic            o_ts_shift,
  output logic      [1:0] o_ts_read_index,
  output logic            o_clear_timestamps,
  output logic            o_charge_enable,
  output logic      [1:0] o_charge_resistor_select,
  output logic      [2:0] o_supply_trip_select,
  output logic            o_switchover_hysteresis_enable,
  output logic      [2:0] o_battery_warn1_trip,
  output logic      [2:0] o_battery_warn2_trip,
  output logic            o_low_supply_flag
);

  logic [7:0]     event_detect_control_q;
  logic [7:0]     event_index_select_q;
  logic [7:0]     charge_control_q;
  logic [7:0]     supply_control_q;
  logic [7:0]     battery_warning_control_q;
  logic [7:0]     event_counter_q;
  logic           clr_pending_q;
  evm_out_state_t out_state_q;
  logic [31:0]    pulse_cnt_q;
  logic           bus_ok;
  logic           wr_ok;
  logic           rd_ok;
  logic           count_clear;
  logic           event_det;
  logic [7:0]     rd_mux;

  evm_cond_if cond_if ();

  // -----------------------------------------------------------------
  // Event input conditioner
  // -----------------------------------------------------------------
  assign cond_if.enable  = event_detect_control_q[EVC_ENABLE];
  assign cond_if.hys_sel = event_detect_control_q[EVC_HYS_LSB +: 2];
  assign cond_if.smp_sel = event_detect_control_q[EVC_SMP_LSB +: 2];
  assign event_det       = cond_if.event_det;

  evm_event_filter #(
    .HYS1_CYC (HYS1_CYC),
    .HYS2_CYC (HYS2_CYC),
    .HYS3_CYC (HYS3_CYC),
    .SMP1_CYC (SMP1_CYC),
    .SMP2_CYC (SMP2_CYC),
    .SMP3_CYC (SMP3_CYC)
  ) u_filter (
    .i_clk_sys         (i_clk_sys),
    .i_srst            (i_srst),
    .i_event_input_pin (i_event_input_pin),
    .cond              (cond_if.cond)
  );

  // -----------------------------------------------------------------
  // Bus gating
  // -----------------------------------------------------------------
  assign bus_ok      = !i_on_battery || supply_control_q[SUP_BUS_BAT];
  assign wr_ok       = i_reg_wr && bus_ok;
  assign rd_ok       = i_reg_rd && bus_ok;
  assign count_clear = wr_ok && (i_reg_addr == ADDR_EVENT_COUNT) && (i_reg_wdata == RST_REG);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_bus_enable <= 1'b1;
    end else begin
      o_bus_enable <= bus_ok;
    end
  end

  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      event_detect_control_q    <= RST_REG;
      event_index_select_q      <= RST_REG;
      charge_control_q          <= RST_REG;
      supply_control_q          <= RST_REG;
      battery_warning_control_q <= RST_REG;
    end else if (wr_ok) begin
      case (i_reg_addr)
        ADDR_EVENT_CTRL:   event_detect_control_q    <= i_reg_wdata & MASK_EVENT_CTRL;
        ADDR_EVENT_INDEX:  event_index_select_q      <= i_reg_wdata & MASK_EVENT_INDEX;
        ADDR_CHARGE_CTRL:  charge_control_q          <= i_reg_wdata & MASK_CHARGE_CTRL;
        ADDR_SUPPLY_CTRL:  supply_control_q          <= i_reg_wdata & MASK_SUPPLY_CTRL;
        ADDR_BATWARN_CTRL: battery_warning_control_q <= i_reg_wdata & MASK_BATWARN_CTRL;
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Analog control outputs
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_charge_enable                <= 1'b0;
      o_charge_resistor_select       <= SEL_OFF;
      o_supply_trip_select           <= 3'h0;
      o_switchover_hysteresis_enable <= 1'b0;
      o_battery_warn1_trip           <= 3'h0;
      o_battery_warn2_trip           <= 3'h0;
      o_low_supply_flag              <= 1'b0;
      o_ts_read_index                <= SEL_OFF;
    end else begin
      o_charge_enable                <= charge_control_q[CHG_ENABLE];
      o_charge_resistor_select       <= charge_control_q[CHG_RES_LSB +: 2];
      o_supply_trip_select           <= supply_control_q[SUP_TRIP_LSB +: 3];
      o_switchover_hysteresis_enable <= battery_warning_control_q[BW_HYS];
      o_battery_warn1_trip           <= battery_warning_control_q[BW_WARN1_LSB +: 3];
      o_battery_warn2_trip           <= battery_warning_control_q[BW_WARN2_LSB +: 3];
      o_low_supply_flag              <= i_supply_below_trip;
      o_ts_read_index                <= event_index_select_q[1:0];
    end
  end

  // -----------------------------------------------------------------
  // Switchover stamp clear
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      clr_pending_q      <= 1'b0;
      o_clear_timestamps <= 1'b0;
    end else begin
      o_clear_timestamps <= clr_pending_q && i_wr_stop;
      if (i_wr_stop) begin
        clr_pending_q <= 1'b0;
      end else if (wr_ok && i_reg_addr == ADDR_SUPPLY_CTRL) begin
        clr_pending_q <= i_reg_wdata[SUP_CLR_TS];
      end
    end
  end

  // -----------------------------------------------------------------
  // Event counter and stamp slots
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || count_clear) begin
      event_counter_q <= RST_REG;
    end else if (event_det && event_counter_q != COUNT_MAX) begin
      event_counter_q <= event_counter_q + 8'd1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ts_capture      <= 1'b0;
      o_ts_capture_slot <= SEL_OFF;
      o_ts_shift        <= 1'b0;
    end else begin
      o_ts_capture <= event_det;
      o_ts_shift   <= event_det && event_counter_q >= 8'd4;
      if (event_det) begin
        if (event_counter_q >= 8'd3) begin
          o_ts_capture_slot <= IDX_LATEST;
        end else begin
          o_ts_capture_slot <= event_counter_q[1:0];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Event detect output
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      out_state_q <= EVO_IDLE;
      pulse_cnt_q <= '0;
    end else begin
      case (out_state_q)
        EVO_IDLE: begin
          if (event_det) begin
            pulse_cnt_q <= '0;
            out_state_q <= event_detect_control_q[EVC_PULSE] ? EVO_PULSE : EVO_LATCH;
          end
        end
        EVO_LATCH: begin
          if (count_clear) begin
            out_state_q <= EVO_IDLE;
          end
        end
        EVO_PULSE: begin
          if (pulse_cnt_q + 32'd1 >= PULSE_CYC) begin
            out_state_q <= EVO_IDLE;
          end else begin
            pulse_cnt_q <= pulse_cnt_q + 32'd1;
          end
        end
        default: out_state_q <= EVO_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_event_detect_output_n <= 1'b1;
    end else if (i_on_battery && event_detect_control_q[EVC_BAT_DIS]) begin
      o_event_detect_output_n <= 1'b1;
    end else begin
      o_event_detect_output_n <= (out_state_q == EVO_IDLE);
    end
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  always_comb begin
    case (i_reg_addr)
      ADDR_EVENT_COUNT:  rd_mux = event_counter_q;
      ADDR_EVENT_CTRL:   rd_mux = event_detect_control_q;
      ADDR_EVENT_INDEX:  rd_mux = event_index_select_q;
      ADDR_CHARGE_CTRL:  rd_mux = charge_control_q;
      ADDR_SUPPLY_CTRL:  rd_mux = supply_control_q;
      ADDR_BATWARN_CTRL: rd_mux = battery_warning_control_q;
      default:           rd_mux = RST_REG;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata <= RST_REG;
    end else if (rd_ok) begin
      o_reg_rdata <= rd_mux;
    end
  end

endmodule : evm_monitor_ctrl

//--- tb/evm_assertions.sv
/*
  Port checker for the event and power monitor control block.
  Assumes one clock, sync active-high reset and field outputs registered.
*/
`timescale 1ns/100ps
module evm_assertions
  import evm_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_wr_stop,
  input wire logic       i_on_battery,
  input wire logic       i_supply_below_trip,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_bus_enable,
  input wire logic       o_event_detect_output_n,
  input wire logic       o_ts_capture,
  input wire logic [1:0] o_ts_capture_slot,
  input wire logic       o_ts_shift,
  input wire logic       o_clear_timestamps,
  input wire logic       o_charge_enable,
  input wire logic [1:0] o_charge_resistor_select,
  input wire logic [2:0] o_supply_trip_select,
  input wire logic       o_switchover_hysteresis_enable,
  input wire logic [2:0] o_battery_warn1_trip,
  input wire logic [2:0] o_battery_warn2_trip,
  input wire logic       o_low_supply_flag
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_low_flag: assert property (!$past(i_srst) |->
    o_low_supply_flag == $past(i_supply_below_trip)) else $error("low supply flag wrong");
  a_clear_pulse: assert property (o_clear_timestamps |->
    $past(i_wr_stop) ##1 !o_clear_timestamps) else $error("clear pulse wrong");
  a_shift_slot: assert property (o_ts_shift |->
    o_ts_capture && o_ts_capture_slot == IDX_LATEST) else $error("shift without latest slot");
  a_fall_cause: assert property ($fell(o_event_detect_output_n) |->
    $past(o_ts_capture)) else $error("event output fell alone");
  a_charge_copy: assert property (i_reg_wr && !i_on_battery &&
    i_reg_addr == ADDR_CHARGE_CTRL |-> ##2 {o_charge_enable, o_charge_resistor_select}
    == $past(i_reg_wdata[2:0], 2)) else $error("charge fields wrong");
  a_trip_copy: assert property (i_reg_wr && !i_on_battery &&
    i_reg_addr == ADDR_SUPPLY_CTRL |-> ##2 o_supply_trip_select
    == $past(i_reg_wdata[2:0], 2)) else $error("trip field wrong");
  a_warn_copy: assert property (i_reg_wr && !i_on_battery &&
    i_reg_addr == ADDR_BATWARN_CTRL |-> ##2 {o_switchover_hysteresis_enable,
    o_battery_warn1_trip, o_battery_warn2_trip} == $past(i_reg_wdata[6:0], 2))
    else $error("battery warning fields wrong");
  a_bus_enable: assert property (!i_on_battery |=> o_bus_enable)
    else $error("bus disabled on main supply");

  c_event_fall: cover property ($fell(o_event_detect_output_n));
  c_clear: cover property (o_clear_timestamps);
  c_shift: cover property (o_ts_shift);
endmodule : evm_assertions

bind evm_monitor_ctrl evm_assertions evm_assertions_inst (.i_clk_sys, .i_srst, .i_reg_wr,
  .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_wr_stop, .i_on_battery, .i_supply_below_trip,
  .o_reg_rdata, .o_bus_enable, .o_event_detect_output_n, .o_ts_capture, .o_ts_capture_slot,
  .o_ts_shift, .o_clear_timestamps, .o_charge_enable, .o_charge_resistor_select,
  .o_supply_trip_select, .o_switchover_hysteresis_enable, .o_battery_warn1_trip,
  .o_battery_warn2_trip, .o_low_supply_flag);

//--- tb/evm_event_switch.sv
/*
  Event switch model: pulls the event input low, with optional bounce.
  Assumes a pull-up, so the line idles high; drives at falling edges.
*/
`timescale 1ns/100ps
module evm_event_switch (
  input  wire logic i_clk_sys,
  output logic      o_level
);
  initial o_level = 1'b1;

  // ---------------------------------------------------------------
  // Bounce, hold low, then idle high as long
  // ---------------------------------------------------------------
  task automatic press(input int glitch, input int hold);
    if (glitch > 0) begin
      @(negedge i_clk_sys);
      o_level = 1'b0;
      repeat (glitch) @(negedge i_clk_sys);
      o_level = 1'b1;
    end
    @(negedge i_clk_sys);
    o_level = 1'b0;
    repeat (hold) @(negedge i_clk_sys);
    o_level = 1'b1;
    repeat (hold) @(negedge i_clk_sys);
  endtask : press
endmodule : evm_event_switch

//--- tb/evm_monitor_ctrl_tb_top.sv
/*
  Testbench for the event and power monitor control block.
  Assumes shortened counts: deglitch 4/8/16, sampling 10/20/40, pulse 25.
*/
`timescale 1ns/100ps
module evm_monitor_ctrl_tb_top;
  import evm_pkg::*;
  localparam int         PULSE   = 25;
  localparam int         HC [4]  = '{0, 4, 8, 16};
  localparam int         SC [4]  = '{0, 10, 20, 40};
  localparam logic [7:0] RA [4]  = '{ADDR_EVENT_INDEX, ADDR_CHARGE_CTRL, ADDR_SUPPLY_CTRL,
                                     ADDR_BATWARN_CTRL};
  localparam logic [7:0] RM [4]  = '{MASK_EVENT_INDEX, MASK_CHARGE_CTRL, MASK_SUPPLY_CTRL,
                                     MASK_BATWARN_CTRL};
  logic       i_clk_sys = 1'b0;
  logic       i_srst = 1'b1;
  logic       i_reg_wr = 1'b0;
  logic       i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic       i_wr_stop = 1'b0;
  logic       i_on_battery = 1'b0;
  logic       i_supply_below_trip = 1'b0;
  logic       i_event_input_pin;
  logic [7:0] o_reg_rdata;
  logic       o_bus_enable, o_event_detect_output_n, o_ts_capture, o_ts_shift;
  logic [1:0] o_ts_capture_slot, o_ts_read_index, o_charge_resistor_select;
  logic       o_clear_timestamps, o_charge_enable, o_switchover_hysteresis_enable;
  logic [2:0] o_supply_trip_select, o_battery_warn1_trip, o_battery_warn2_trip;
  logic       o_low_supply_flag;
  int         n_mismatch = 0;
  int         checks = 0;

  always #5 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) i_supply_below_trip <= 1'($urandom_range(1));

  evm_event_switch evm_event_switch_inst (.i_clk_sys, .o_level(i_event_input_pin));
  evm_monitor_ctrl #(.HYS1_CYC(HC[1]), .HYS2_CYC(HC[2]), .HYS3_CYC(HC[3]), .SMP1_CYC(SC[1]),
    .SMP2_CYC(SC[2]), .SMP3_CYC(SC[3]), .PULSE_CYC(PULSE)) evm_monitor_ctrl_inst (.i_clk_sys,
    .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_wr_stop, .i_on_battery,
    .i_supply_below_trip, .i_event_input_pin, .o_reg_rdata, .o_bus_enable,
    .o_event_detect_output_n, .o_ts_capture, .o_ts_capture_slot, .o_ts_shift,
    .o_ts_read_index, .o_clear_timestamps, .o_charge_enable, .o_charge_resistor_select,
    .o_supply_trip_select, .o_switchover_hysteresis_enable, .o_battery_warn1_trip,
    .o_battery_warn2_trip, .o_low_supply_flag);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_len(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("MISMATCH %0t length %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_len

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic ev(input int g, input int h);
    evm_event_switch_inst.press(g, h);
  endtask : ev

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int         n, k;
    void'($urandom(66));
    repeat (16) @(negedge i_clk_sys);
    i_srst = 1'b0;
    for (k = 0; k < 12; k++) begin
      n = $urandom_range(3);
      d = 8'($urandom);
      wr(RA[n], d);
      rd_chk(RA[n], d & RM[n]);
      if (n == 0) chk({6'h00, o_ts_read_index}, {6'h00, d[1:0]});
    end
    wr(8'h3C, 8'hFF);
    rd_chk(8'h3C, 8'h00);
    wr(ADDR_SUPPLY_CTRL, 8'h80);
    i_wr_stop = 1'b1;
    @(negedge i_clk_sys);
    i_wr_stop = 1'b0;
    chk({7'h00, o_clear_timestamps}, 8'h01);
    rd_chk(ADDR_SUPPLY_CTRL, 8'h00);
    wr(ADDR_EVENT_CTRL, 8'h10);
    ev(0, 6);
    rd_chk(ADDR_EVENT_COUNT, 8'h01);
    repeat (40) @(negedge i_clk_sys);
    chk({7'h00, o_event_detect_output_n}, 8'h00);
    wr(ADDR_EVENT_COUNT, 8'h00);
    repeat (4) @(negedge i_clk_sys);
    chk({7'h00, o_event_detect_output_n}, 8'h01);
    for (k = 0; k < 16; k++) begin
      wr(ADDR_EVENT_CTRL, 8'h10 | 8'(k));
      wr(ADDR_EVENT_COUNT, 8'h00);
      ev((k > 3) ? HC[k / 4] - 1 : 0, HC[k / 4] + SC[k % 4] + 4);
      rd_chk(ADDR_EVENT_COUNT, 8'h01);
    end
    wr(ADDR_EVENT_CTRL, 8'h00);
    wr(ADDR_EVENT_COUNT, 8'h00);
    ev(0, 6);
    rd_chk(ADDR_EVENT_COUNT, 8'h00);
    wr(ADDR_EVENT_CTRL, 8'h30);
    fork
      ev(0, 4);
    join_none
    n = 0;
    for (k = 0; k < 20 && o_event_detect_output_n; k++) @(negedge i_clk_sys);
    while (!o_event_detect_output_n && n < 60) begin
      n++;
      @(negedge i_clk_sys);
    end
    chk_len(n, PULSE * 200 / 250, PULSE * 300 / 250);
    wr(ADDR_EVENT_CTRL, 8'h10);
    wr(ADDR_EVENT_COUNT, 8'h00);
    for (k = 0; k < 260; k++) ev(0, 2);
    rd_chk(ADDR_EVENT_COUNT, COUNT_MAX);
    wr(ADDR_CHARGE_CTRL, 8'h02);
    i_on_battery = 1'b1;
    wr(ADDR_CHARGE_CTRL, 8'h05);
    rd(ADDR_CHARGE_CTRL, d);
    chk(d, COUNT_MAX);
    chk({5'h00, o_charge_enable, o_charge_resistor_select}, 8'h02);
    chk({7'h00, o_bus_enable}, 8'h00);
    i_on_battery = 1'b0;
    wr(ADDR_SUPPLY_CTRL, 8'h20);
    i_on_battery = 1'b1;
    wr(ADDR_EVENT_COUNT, 8'h00);
    ev(0, 6);
    chk({o_bus_enable, o_event_detect_output_n}, 8'h02);
    wr(ADDR_EVENT_COUNT, 8'h00);
    wr(ADDR_EVENT_CTRL, 8'h50);
    ev(0, 6);
    chk({7'h00, o_event_detect_output_n}, 8'h01);
    rd_chk(ADDR_EVENT_COUNT, 8'h01);
    wr(ADDR_EVENT_COUNT, 8'h00);
    i_on_battery = 1'b0;
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge i_clk_sys);
    n_mismatch++;
    end_of_test();
  end
endmodule : evm_monitor_ctrl_tb_top
